// [rcpd_pkg.sv]
package rcpd_pkg;
  // Register offsets (index per byte register)
  localparam logic [7:0] RCPD_ADDR_RESET_CAUSE = 8'h00;
  localparam logic [7:0] RCPD_ADDR_STOP_CTRL   = 8'h01;
  localparam logic [7:0] RCPD_ADDR_CLK_SEL     = 8'h02;
  localparam logic [7:0] RCPD_ADDR_OPTIONS     = 8'h03;
  localparam logic [7:0] RCPD_ADDR_STATUS      = 8'h04;
  localparam logic [7:0] RCPD_ADDR_STAB_CNT    = 8'h05;
  // Reset-cause field positions
  localparam int RCPD_BIT_POR = 0;
  localparam int RCPD_BIT_LVR = 1;
  localparam int RCPD_BIT_WDT = 2;
  localparam int RCPD_BIT_PIN = 4;
  localparam logic [7:0] RCPD_CAUSE_MASK = 8'h17;
  // Clock-select field: bits 4:3, 00 selects divide-by-16
  localparam int RCPD_CLK_LO = 3;
  localparam int RCPD_CLK_HI = 4;
  localparam logic [7:0] RCPD_CLK_SEL_RST = 8'h00;
  // Stop enabling pattern
  localparam logic [7:0] RCPD_STOP_KEY = 8'ha5;
  localparam logic [7:0] RCPD_STOP_RST = 8'h00;
  // Options: bit0 ring oscillator runs in stop, bit1 low-voltage reset on
  localparam int RCPD_OPT_RING = 0;
  localparam int RCPD_OPT_LVR  = 1;
  localparam logic [7:0] RCPD_OPT_RST = 8'h00;
  // Stabilization count default
  localparam logic [7:0] RCPD_STAB_RST = 8'hff;
  // Reset vector
  localparam logic [15:0] RCPD_RESET_VECTOR = 16'h0100;
  // Power state
  typedef enum logic [1:0] {
    RCPD_RUN  = 2'b00,
    RCPD_STOP = 2'b01,
    RCPD_IDLE = 2'b10,
    RCPD_WAKE = 2'b11
  } rcpd_state_t;
endpackage

// [rcpd_sync.sv]
`timescale 1ns/1ps
// Three-stage synchroniser; change accepted when stages two and three agree
module rcpd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Shift chain
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per-bit agreement filter
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          sync_out[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule // rcpd_sync

// [rcpd_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Writing zero to a reset-cause flag clears it.
// - Writing one to low-voltage, watchdog or pin flags changes nothing.
// - Bit 1 reads one after a low-voltage reset.
// - Bit 0 reads one after a power-on reset.
// - Watchdog and pin resets set flags of every active source.
// - Power-on clears bits 4 and 2, sets bit 0, bit 1 if enabled.
// - Flags keep their value across resets that do not touch them.
// - Bits 7 to 5 and 3 read zero and ignore writes.
// - Stop halts oscillator, CPU and peripherals; registers keep data.
// - Ring oscillator running in stop is selectable.
// - Leaving stop clears the stop control register.
// - Pin reset from stop or idle restores defaults, clock select 00.
// - After reset and stabilization the CPU fetches from 0100h.
// - Filtered external interrupts 0 to 7 wake from stop.
// - Interrupt wake keeps control registers and clock selection.
// - Waking interrupt is serviced, then code resumes after stop.
// - Enabled internal interrupts also release stop.
// - Idle gates the CPU clock while peripheral timers run.
// - Port directions are held during idle.
// - With all interrupts masked only reset releases idle.
// - Enabled interrupts release idle with clock select unchanged.
// - Stabilization after interrupt wake uses settings made before stop.
module rcpd_top
  import rcpd_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Reset sources, all asynchronous levels
  input  wire logic        por_event,
  input  wire logic        lvr_event,
  input  wire logic        wdt_event,
  input  wire logic        external_reset_pin_n,
  // Wake sources
  input  wire logic [7:0]  ext_int_req,
  input  wire logic [7:0]  ext_int_en,
  input  wire logic        int_wake_req,
  // CPU core
  input  wire logic        stop_exec,
  input  wire logic        idle_exec,
  input  wire logic        int_service_done,
  input  wire logic [7:0]  port_dir_in,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Power control outputs
  output logic             main_osc_en,
  output logic             ring_osc_en,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic      [1:0]  clk_div_sel,
  output logic      [7:0]  port_dir_out,
  output logic             wake_int_pend,
  output logic             cpu_vector_load,
  output logic      [15:0] cpu_vector
);

  logic [3:0]  rst_src;
  logic        pin_rst;
  logic        lvr_rst;
  logic        wdt_rst;
  logic        por_q;
  logic        hold_q;
  logic [7:0]  cause_q;
  logic [7:0]  stop_ctrl_q;
  logic [7:0]  clk_sel_q;
  logic [7:0]  opt_q;
  logic [7:0]  stab_q;
  logic [7:0]  stab_cnt_q;
  logic [7:0]  ext_int_s;
  logic        wake;
  logic        stop_armed;
  rcpd_state_t state_q;

  // Reset and interrupt pins cross into the system clock
  rcpd_sync #(.W(4)) u_rst_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in ({por_event, ~external_reset_pin_n, lvr_event, wdt_event}),
    .sync_out (rst_src)
  );

  rcpd_sync #(.W(8)) u_int_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in (ext_int_req),
    .sync_out (ext_int_s)
  );

  assign pin_rst = rst_src[2];
  assign lvr_rst = rst_src[1];
  assign wdt_rst = rst_src[0];

  // Byte write merge for write-zero-to-clear flags
  function automatic logic [7:0] w0c(input logic [7:0] cur,
                                     input logic [7:0] wd);
    w0c = cur & wd & RCPD_CAUSE_MASK;
  endfunction

  // Wake when any enabled external or internal interrupt fires
  assign wake = (|(ext_int_s & ext_int_en)) | int_wake_req;
  assign stop_armed = (stop_ctrl_q == RCPD_STOP_KEY);

  // Power-on indication: held in reset while por_event high
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      por_q <= 1'b1;
    end else begin
      por_q <= rst_src[3];
    end
  end

  // Any system reset source active
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= 1'b1;
    end else begin
      hold_q <= por_q | pin_rst | lvr_rst | wdt_rst;
    end
  end

  // Reset-cause flags
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cause_q <= 8'h01;
    end else if (por_q) begin
      cause_q <= 8'h01;
      cause_q[RCPD_BIT_LVR] <= opt_q[RCPD_OPT_LVR];
    end else begin
      if (reg_wr && reg_addr == RCPD_ADDR_RESET_CAUSE) begin
        cause_q <= w0c(cause_q, reg_wdata);
      end
      // Set wins over a simultaneous clear; other bits keep value
      if (lvr_rst) begin
        cause_q[RCPD_BIT_LVR] <= 1'b1;
      end
      if (wdt_rst) begin
        cause_q[RCPD_BIT_WDT] <= 1'b1;
      end
      if (pin_rst) begin
        cause_q[RCPD_BIT_PIN] <= 1'b1;
      end
    end
  end

  // Option register: cleared only by rstn; survives power-on and all other resets
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      opt_q <= RCPD_OPT_RST;
    end else if (reg_wr && reg_addr == RCPD_ADDR_OPTIONS) begin
      opt_q <= reg_wdata & 8'h03;
    end
  end

  // Stop control register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stop_ctrl_q <= RCPD_STOP_RST;
    end else if (hold_q) begin
      stop_ctrl_q <= RCPD_STOP_RST;
    end else if (state_q == RCPD_STOP && wake) begin
      stop_ctrl_q <= RCPD_STOP_RST;
    end else if (reg_wr && reg_addr == RCPD_ADDR_STOP_CTRL) begin
      stop_ctrl_q <= reg_wdata;
    end
  end

  // Clock select; only a reset or a write of 00 returns it to divide-by-16
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clk_sel_q <= RCPD_CLK_SEL_RST;
    end else if (hold_q) begin
      clk_sel_q <= RCPD_CLK_SEL_RST;
    end else if (reg_wr && reg_addr == RCPD_ADDR_CLK_SEL) begin
      clk_sel_q <= reg_wdata;
    end
  end

  // Stabilization count, programmed before stop
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stab_q <= RCPD_STAB_RST;
    end else if (hold_q) begin
      stab_q <= RCPD_STAB_RST;
    end else if (reg_wr && reg_addr == RCPD_ADDR_STAB_CNT) begin
      stab_q <= reg_wdata;
    end
  end

  // Power state machine
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= RCPD_WAKE;
    end else if (hold_q) begin
      state_q <= RCPD_WAKE;
    end else begin
      case (state_q)
        RCPD_RUN: begin
          if (stop_exec && stop_armed) begin
            state_q <= RCPD_STOP;
          end else if (idle_exec) begin
            state_q <= RCPD_IDLE;
          end
        end
        RCPD_STOP: begin
          if (wake) begin
            state_q <= RCPD_WAKE;
          end
        end
        RCPD_IDLE: begin
          if (wake) begin
            state_q <= RCPD_RUN;
          end
        end
        RCPD_WAKE: begin
          if (stab_cnt_q >= stab_q) begin
            state_q <= RCPD_RUN;
          end
        end
        default: state_q <= RCPD_RUN;
      endcase
    end
  end

  // Stabilization counter on the restarted oscillator
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stab_cnt_q <= 8'h00;
    end else if (state_q != RCPD_WAKE || hold_q) begin
      stab_cnt_q <= 8'h00;
    end else if (stab_cnt_q != 8'hff) begin
      stab_cnt_q <= stab_cnt_q + 8'h01;
    end
  end

  // Reset vector flag: set on reset, used once stabilized
  logic from_reset_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      from_reset_q <= 1'b1;
    end else if (hold_q) begin
      from_reset_q <= 1'b1;
    end else if (state_q == RCPD_WAKE && stab_cnt_q >= stab_q) begin
      from_reset_q <= 1'b0;
    end
  end

  // CPU vector load after reset release and stabilization
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_vector_load <= 1'b0;
      cpu_vector      <= RCPD_RESET_VECTOR;
    end else begin
      cpu_vector_load <= !hold_q && from_reset_q &&
                         state_q == RCPD_WAKE &&
                         stab_cnt_q >= stab_q;
      cpu_vector      <= RCPD_RESET_VECTOR;
    end
  end

  // Pending wake interrupt: serviced before resuming after stop or idle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wake_int_pend <= 1'b0;
    end else if (hold_q) begin
      wake_int_pend <= 1'b0;
    end else if ((state_q == RCPD_STOP || state_q == RCPD_IDLE) && wake) begin
      wake_int_pend <= 1'b1;
    end else if (int_service_done) begin
      wake_int_pend <= 1'b0;
    end
  end

  // Port directions captured on idle entry and held
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      port_dir_out <= 8'h00;
    end else if (state_q != RCPD_IDLE) begin
      port_dir_out <= port_dir_in;
    end
  end

  // Clock gating outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      main_osc_en   <= 1'b1;
      ring_osc_en   <= 1'b1;
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
      clk_div_sel   <= 2'b00;
    end else begin
      main_osc_en   <= (state_q != RCPD_STOP);
      ring_osc_en   <= (state_q != RCPD_STOP) | opt_q[RCPD_OPT_RING];
      cpu_clk_en    <= (state_q == RCPD_RUN) && !hold_q;
      periph_clk_en <= (state_q == RCPD_RUN || state_q == RCPD_IDLE)
                       && !hold_q;
      clk_div_sel   <= clk_sel_q[RCPD_CLK_HI:RCPD_CLK_LO];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        RCPD_ADDR_RESET_CAUSE: reg_rdata <= cause_q & RCPD_CAUSE_MASK;
        RCPD_ADDR_STOP_CTRL:   reg_rdata <= stop_ctrl_q;
        RCPD_ADDR_CLK_SEL:     reg_rdata <= clk_sel_q;
        RCPD_ADDR_OPTIONS:     reg_rdata <= opt_q;
        RCPD_ADDR_STATUS:      reg_rdata <= {6'h00, state_q};
        RCPD_ADDR_STAB_CNT:    reg_rdata <= stab_q;
        default:               reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // rcpd_top

// [rcpd_top_sva.sv]
`timescale 1ns/1ps
// Port-level checker for the reset-cause and power-down block
module rcpd_top_sva
  import rcpd_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // Register port
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_rdata,
  // Core side
  input wire logic        idle_exec,
  input wire logic        int_service_done,
  // Power control outputs
  input wire logic        main_osc_en,
  input wire logic        cpu_clk_en,
  input wire logic        periph_clk_en,
  input wire logic [7:0]  port_dir_out,
  input wire logic        wake_int_pend,
  input wire logic        cpu_vector_load,
  input wire logic [15:0] cpu_vector
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Read data only in the answer cycle
  a_rdata_quiet_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_cause_unused_zero: assert property
    (reg_rd && reg_addr == RCPD_ADDR_RESET_CAUSE
     |=> (reg_rdata & ~RCPD_CAUSE_MASK) == 8'h00)
    else $error("unused cause bits not zero");
  // Power states
  a_stop_halts_all: assert property
    (!main_osc_en |-> !cpu_clk_en && !periph_clk_en)
    else $error("clocks running with oscillator off");
  a_idle_gates_cpu: assert property
    (idle_exec && cpu_clk_en |-> ##[1:2] (!cpu_clk_en && periph_clk_en))
    else $error("idle did not gate core clock");
  a_idle_ports_held: assert property
    (!cpu_clk_en && periph_clk_en && $past(!cpu_clk_en && periph_clk_en)
     |-> $stable(port_dir_out))
    else $error("port direction changed in idle");
  // Restart and interrupt return
  a_vector_fetch_start: assert property
    (cpu_vector_load |-> cpu_vector == RCPD_RESET_VECTOR ##1 cpu_clk_en)
    else $error("bad restart vector or clock");
  a_vector_one_pulse: assert property
    (cpu_vector_load |=> !cpu_vector_load)
    else $error("vector load longer than one cycle");
  a_pend_until_return: assert property
    (wake_int_pend && !int_service_done |=> wake_int_pend)
    else $error("wake interrupt dropped before return");
endmodule // rcpd_top_sva

bind rcpd_top rcpd_top_sva rcpd_top_sva_inst (.*);

// [rcpd_cpu_model.sv]
`timescale 1ns/1ps
// Core model: returns from the waking interrupt after a service delay
module rcpd_cpu_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Core side
  input  wire logic       cpu_clk_en,
  input  wire logic       wake_int_pend,
  input  wire logic [3:0] svc_lat,
  output logic            int_service_done
);
  logic [3:0] cnt_q;

  // Service runs only while the core is clocked; return is one pulse
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      int_service_done <= 1'b0;
    end else begin
      int_service_done <= 1'b0;
      if (!(wake_int_pend && cpu_clk_en) || int_service_done) begin
        cnt_q <= 4'h0;
      end else if (cnt_q == svc_lat) begin
        int_service_done <= 1'b1;
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule // rcpd_cpu_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import rcpd_pkg::*;
  // Stimulus
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        por_event = 1'b0;
  logic        lvr_event = 1'b0;
  logic        wdt_event = 1'b0;
  logic        external_reset_pin_n = 1'b1;
  logic [7:0]  ext_int_req = 8'h00;
  logic [7:0]  ext_int_en = 8'h00;
  logic        int_wake_req = 1'b0;
  logic        stop_exec = 1'b0;
  logic        idle_exec = 1'b0;
  logic [7:0]  port_dir_in = 8'h5a;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  svc_lat = 4'h3;
  // Observed
  logic        int_service_done;
  logic [7:0]  reg_rdata;
  logic        main_osc_en;
  logic        ring_osc_en;
  logic        cpu_clk_en;
  logic        periph_clk_en;
  logic [1:0]  clk_div_sel;
  logic [7:0]  port_dir_out;
  logic        wake_int_pend;
  logic        cpu_vector_load;
  logic [15:0] cpu_vector;
  int          num_errors = 0;
  int          samples_checked = 0;

  rcpd_top rcpd_top_inst (.*);
  rcpd_cpu_model rcpd_cpu_model_inst (.*);

  always #5 sys_clk = ~sys_clk;

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic wait_run();
    int i;
    i = 0;
    while (cpu_clk_en !== 1'b1 && i < 1000) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk("cpu_clk_en", 16'h1, {15'h0, cpu_clk_en});
  endtask
  // Hold the chosen reset sources, release, wait for restart
  task automatic src(input logic l, input logic w, input logic p);
    @(posedge sys_clk);
    lvr_event <= l;
    wdt_event <= w;
    external_reset_pin_n <= !p;
    cyc(8);
    lvr_event <= 1'b0;
    wdt_event <= 1'b0;
    external_reset_pin_n <= 1'b1;
    cyc(8);
    wait_run();
  endtask
  task automatic pulse_stop();
    wr(RCPD_ADDR_STOP_CTRL, RCPD_STOP_KEY);
    @(posedge sys_clk);
    stop_exec <= 1'b1;
    @(posedge sys_clk);
    stop_exec <= 1'b0;
    cyc(3);
  endtask

  task automatic t_cause();
    wait_run();
    rdchk(RCPD_ADDR_RESET_CAUSE, 8'h01);
    rdchk(8'h40, 8'h00);
    wr(RCPD_ADDR_RESET_CAUSE, 8'hff);
    rdchk(RCPD_ADDR_RESET_CAUSE, 8'h01);
    wr(RCPD_ADDR_RESET_CAUSE, 8'h00);
    rdchk(RCPD_ADDR_RESET_CAUSE, 8'h00);
    src(1'b0, 1'b1, 1'b1);
    rdchk(RCPD_ADDR_RESET_CAUSE, 8'h14);
    wr(RCPD_ADDR_RESET_CAUSE, 8'h00);
    src(1'b1, 1'b0, 1'b0);
    rdchk(RCPD_ADDR_RESET_CAUSE, 8'h02);
    $display("test cause done");
  endtask
  task automatic t_stop_int();
    wr(RCPD_ADDR_OPTIONS, 8'h01);
    wr(RCPD_ADDR_STAB_CNT, 8'h20);
    wr(RCPD_ADDR_CLK_SEL, 8'h18);
    pulse_stop();
    chk("main_osc_en", 16'h0, {15'h0, main_osc_en});
    chk("ring_osc_en", 16'h1, {15'h0, ring_osc_en});
    rdchk(RCPD_ADDR_STATUS, 8'h01);
    ext_int_en <= 8'h01;
    cyc(2);
    ext_int_req <= 8'h01;
    cyc(10);
    ext_int_req <= 8'h00;
    chk("cpu_clk_en", 16'h0, {15'h0, cpu_clk_en});
    wait_run();
    chk("wake_int_pend", 16'h1, {15'h0, wake_int_pend});
    chk("clk_div_sel", 16'h3, {14'h0, clk_div_sel});
    rdchk(RCPD_ADDR_STOP_CTRL, 8'h00);
    cyc(20);
    chk("wake_int_pend", 16'h0, {15'h0, wake_int_pend});
    $display("test stop interrupt done");
  endtask
  task automatic t_idle();
    svc_lat <= 4'h9;
    ext_int_en <= 8'h00;
    @(posedge sys_clk);
    idle_exec <= 1'b1;
    @(posedge sys_clk);
    idle_exec <= 1'b0;
    cyc(3);
    chk("periph_clk_en", 16'h1, {15'h0, periph_clk_en});
    port_dir_in <= 8'ha5;
    ext_int_req <= 8'h01;
    cyc(20);
    chk("port_dir_out", 16'h5a, {8'h0, port_dir_out});
    chk("cpu_clk_en", 16'h0, {15'h0, cpu_clk_en});
    ext_int_req <= 8'h00;
    int_wake_req <= 1'b1;
    wait_run();
    int_wake_req <= 1'b0;
    chk("clk_div_sel", 16'h3, {14'h0, clk_div_sel});
    cyc(30);
    chk("wake_int_pend", 16'h0, {15'h0, wake_int_pend});
    $display("test idle done");
  endtask
  task automatic t_stop_pin();
    wr(RCPD_ADDR_OPTIONS, 8'h00);
    // Internal interrupt releases stop with clock select kept
    pulse_stop();
    int_wake_req <= 1'b1;
    @(posedge sys_clk);
    int_wake_req <= 1'b0;
    wait_run();
    chk("clk_div_sel", 16'h3, {14'h0, clk_div_sel});
    rdchk(RCPD_ADDR_STOP_CTRL, 8'h00);
    cyc(20);
    chk("wake_int_pend", 16'h0, {15'h0, wake_int_pend});
    pulse_stop();
    chk("ring_osc_en", 16'h0, {15'h0, ring_osc_en});
    src(1'b0, 1'b0, 1'b1);
    chk("clk_div_sel", 16'h0, {14'h0, clk_div_sel});
    rdchk(RCPD_ADDR_STOP_CTRL, 8'h00);
    rdchk(RCPD_ADDR_RESET_CAUSE, 8'h12);
    // Power-on with low-voltage reset enabled
    wr(RCPD_ADDR_OPTIONS, 8'h02);
    @(posedge sys_clk);
    por_event <= 1'b1;
    cyc(8);
    por_event <= 1'b0;
    cyc(8);
    wait_run();
    rdchk(RCPD_ADDR_RESET_CAUSE, 8'h03);
    $display("test stop pin done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    cyc(20);
    rstn <= 1'b1;
    t_cause();
    t_stop_int();
    t_idle();
    t_stop_pin();
    test_done();
  end
  // Watchdog
  initial begin
    #400000;
    num_errors++;
    test_done();
  end
endmodule // tb_top
